/* rtl/dvt_pkg.sv */
// Purpose: Shared constants and types for the video line timing block.
// Assumes: APB byte addresses, 32-bit data, lane byte clock for the link.
// Notes:   Timing fields count lane byte clock cycles.
package dvt_pkg;
   localparam int        AW          = 8;
   localparam int        DW          = 32;
   localparam int        TW          = 12;
   localparam logic [AW-1:0] OFF_PWR = 8'h04;
   localparam logic [AW-1:0] OFF_VID = 8'h1C;
   localparam logic [AW-1:0] OFF_CMD = 8'h24;
   localparam logic [AW-1:0] OFF_SYNCW = 8'h30;
   localparam logic [AW-1:0] OFF_PORCH = 8'h34;
   localparam logic [AW-1:0] OFF_ACT = 8'h38;
   localparam logic [AW-1:0] OFF_HFP = 8'h3C;
   localparam logic [AW-1:0] OFF_NUL = 8'h40;
   localparam logic [AW-1:0] OFF_STA = 8'h44;
   localparam int        PWR_BIT     = 0;
   localparam int        VID_EN_BIT  = 0;
   localparam int        NULL_EN_BIT = 1;
   localparam int        MULTI_BIT   = 2;
   localparam int        PULSE_BIT   = 3;
   localparam int        CMD_EN_BIT  = 0;
   localparam int        CNT_W       = 16;
   localparam logic [TW-1:0] SYNCW_RST = 12'h00B;
   localparam logic [TW-1:0] PORCH_RST = 12'h00B;
   localparam logic [TW-1:0] ACT_RST = 12'h040;
   localparam logic [TW-1:0] HFP_RST = 12'h008;
   localparam logic [TW-1:0] NUL_RST = 12'h004;
   localparam logic [TW-1:0] HSS_BYTES = 12'h004;
   localparam logic [TW-1:0] BLANK_MIN = 12'h006;
   localparam logic [7:0] DT_HSS   = 8'h21;
   localparam logic [7:0] DT_BLANK = 8'h19;
   localparam logic [7:0] DT_NULL  = 8'h09;
   typedef enum logic [5:0] {
      ST_IDLE  = 6'h01,
      ST_SYNC  = 6'h02,
      ST_PORCH = 6'h04,
      ST_ACT   = 6'h08,
      ST_HFP   = 6'h10,
      ST_NULD  = 6'h20
   } dvt_state_t;
endpackage

/* rtl/dvt_sync_if.sv */
// Purpose: Carries one level across a clock boundary.
// Assumes: raw is driven in the source domain.
// Notes:   q belongs to the destination domain.
`timescale 1ns/1ps
interface dvt_sync_if;
   logic raw;
   logic q;
   modport src (output raw, input q);
   modport dst (input raw, output q);
endinterface

/* rtl/dvt_sync.sv */
// Purpose: Three-stage synchroniser with agreement filter.
// Assumes: clk_i is the destination clock.
// Notes:   The output follows only when stages two and three agree.
`timescale 1ns/1ps
module dvt_sync (
   input  wire logic clk_i,   // Destination clock.
   input  wire logic rst_b_i, // Asynchronous reset, active low.
   dvt_sync_if.dst   s        // Level in, filtered level out.
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= s.raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s.q <= 1'b0;
      end else if (s2_q == s3_q) begin
         s.q <= s3_q;
      end
   end
endmodule

/* rtl/dvt_top.sv */
// Purpose: Line timing scheduler for video mode with an APB register file.
// Assumes: Pixel input port runs on the lane byte clock.
// Notes:   Mode and timing words are taken into the link domain only while
//          the core is held in reset.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
module dvt_top (
   input  wire logic                  CLOCK_I,      // APB clock, 40 MHz.
   input  wire logic                  RST_B_I,      // Async reset, active low.
   input  wire logic                  PSEL_I,       // APB select.
   input  wire logic                  PENABLE_I,    // APB access phase.
   input  wire logic                  PWRITE_I,     // APB write.
   input  wire logic [dvt_pkg::AW-1:0] PADDR_I,     // APB byte address.
   input  wire logic [dvt_pkg::DW-1:0] PWDATA_I,    // APB write data.
   output logic      [dvt_pkg::DW-1:0] PRDATA_O,    // APB read data.
   output logic                       PREADY_O,     // APB ready.
   output logic                       PSLVERR_O,    // APB error.
   input  wire logic                  LANE_CLK_I,   // Lane byte clock.
   input  wire logic [7:0]            PIX_DATA_I,   // Pixel byte in.
   output logic                       PIX_READY_O,  // Pixel byte taken.
   output logic      [7:0]            LANE_DATA_O,  // Lane byte out.
   output logic                       LANE_VALID_O  // Lane byte valid.
);
   import dvt_pkg::*;

   logic [DW-1:0]    vid_q;
   logic [DW-1:0]    cmd_q;
   logic             pwr_q;
   logic [TW-1:0]    syncw_q;
   logic [TW-1:0]    porch_q;
   logic [TW-1:0]    act_q;
   logic [TW-1:0]    hfp_q;
   logic [TW-1:0]    nul_q;
   logic [CNT_W-1:0] lines_q;
   logic             line_seen_q;
   logic             setup;
   logic             access;
   logic             hit;
   logic [DW-1:0]    rd_d;

   dvt_sync_if pwr_sif ();
   dvt_sync_if line_sif ();

   // APB side: ready comes one cycle into the access phase.
   assign setup  = PSEL_I & PENABLE_I & ~PREADY_O;
   assign access = PSEL_I & PENABLE_I & PREADY_O;

   always_comb begin
      hit  = 1'b1;
      rd_d = '0;
      case (PADDR_I)
         OFF_PWR: rd_d[PWR_BIT] = pwr_q;
         OFF_VID: rd_d = vid_q;
         OFF_CMD: rd_d = cmd_q;
         OFF_SYNCW: rd_d[TW-1:0] = syncw_q;
         OFF_PORCH: rd_d[TW-1:0] = porch_q;
         OFF_ACT: rd_d[TW-1:0] = act_q;
         OFF_HFP: rd_d[TW-1:0] = hfp_q;
         OFF_NUL: rd_d[TW-1:0] = nul_q;
         OFF_STA: rd_d[CNT_W-1:0] = lines_q;
         default: hit = 1'b0;
      endcase
   end

   always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         PREADY_O  <= 1'b0;
         PSLVERR_O <= 1'b0;
         PRDATA_O  <= '0;
      end else begin
         PREADY_O  <= setup;
         PSLVERR_O <= setup & ~hit;
         if (setup && !PWRITE_I) begin
            PRDATA_O <= rd_d;
         end
      end
   end

   always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         pwr_q <= 1'b0;
      end else if (access && PWRITE_I && PADDR_I == OFF_PWR) begin
         pwr_q <= PWDATA_I[PWR_BIT];
      end
   end

   always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         vid_q <= '0;
         cmd_q <= '0;
      end else if (access && PWRITE_I) begin
         if (PADDR_I == OFF_VID) begin
            vid_q <= PWDATA_I;
         end
         if (PADDR_I == OFF_CMD) begin
            cmd_q <= PWDATA_I;
         end
      end
   end

   always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         syncw_q <= SYNCW_RST;
         porch_q <= PORCH_RST;
         act_q <= ACT_RST;
         hfp_q <= HFP_RST;
         nul_q <= NUL_RST;
      end else if (access && PWRITE_I) begin
         case (PADDR_I)
            OFF_SYNCW: syncw_q <= PWDATA_I[TW-1:0];
            OFF_PORCH: porch_q <= PWDATA_I[TW-1:0];
            OFF_ACT: act_q <= PWDATA_I[TW-1:0];
            OFF_HFP: hfp_q <= PWDATA_I[TW-1:0];
            OFF_NUL: nul_q <= PWDATA_I[TW-1:0];
            default: ;
         endcase
      end
   end

   // Line starts arrive as a toggle; each change counts one line.
   always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         line_seen_q <= 1'b0;
         lines_q     <= '0;
      end else begin
         line_seen_q <= line_sif.q;
         if (line_sif.q != line_seen_q) begin
            lines_q <= lines_q + CNT_W'(1);
         end
      end
   end

   assign pwr_sif.raw = pwr_q;

   dvt_sync u_pwr_sync (
      .clk_i   (LANE_CLK_I),
      .rst_b_i (RST_B_I),
      .s       (pwr_sif)
   );

   dvt_sync u_line_sync (
      .clk_i   (CLOCK_I),
      .rst_b_i (RST_B_I),
      .s       (line_sif)
   );

   // Link domain.
   logic          run;
   logic          vid_en_q;
   logic          cmd_en_q;
   logic          null_en_q;
   logic          multi_q;
   logic          pulse_q;
   logic [TW-1:0] l_syncw_q;
   logic [TW-1:0] l_porch_q;
   logic [TW-1:0] l_act_q;
   logic [TW-1:0] l_hfp_q;
   logic [TW-1:0] l_nul_q;
   logic          send_bp;
   logic          null_dly;
   dvt_state_t    state_q;
   dvt_state_t    state_d;
   logic [TW-1:0] cnt_q;
   logic [TW-1:0] cnt_d;
   logic [TW-1:0] cur_len;
   logic          seg_end;
   logic          line_tgl_q;
   logic          lane_v_d;
   logic [7:0]    lane_b_d;

   assign run = pwr_sif.q;

   // The mode and timing words cross without synchronisers. This is safe
   // only because they are copied while the core is held, and software
   // leaves them alone until the release has passed the synchroniser.
   // copy modes while held
   always_ff @(posedge LANE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         vid_en_q  <= 1'b0;
         cmd_en_q  <= 1'b0;
         null_en_q <= 1'b0;
         multi_q   <= 1'b0;
         pulse_q   <= 1'b0;
         l_syncw_q <= SYNCW_RST;
         l_porch_q <= PORCH_RST;
         l_act_q   <= ACT_RST;
         l_hfp_q   <= HFP_RST;
         l_nul_q   <= NUL_RST;
      end else if (!run) begin
         vid_en_q  <= vid_q[VID_EN_BIT];
         cmd_en_q  <= cmd_q[CMD_EN_BIT];
         null_en_q <= vid_q[NULL_EN_BIT];
         multi_q   <= vid_q[MULTI_BIT];
         pulse_q   <= vid_q[PULSE_BIT];
         l_syncw_q <= syncw_q;
         l_porch_q <= porch_q;
         l_act_q   <= act_q;
         l_hfp_q   <= hfp_q;
         l_nul_q   <= nul_q;
      end
   end

   assign send_bp = pulse_q && (l_porch_q >= BLANK_MIN);
   assign null_dly = null_en_q & multi_q;

   always_comb begin
      case (state_q)
         ST_SYNC:  cur_len = l_syncw_q;
         ST_PORCH: cur_len = l_porch_q;
         ST_ACT:  cur_len = l_act_q;
         ST_HFP:  cur_len = l_hfp_q;
         ST_NULD: cur_len = l_nul_q;
         default: cur_len = '0;
      endcase
   end

   assign seg_end = ({1'b0, cnt_q} + 13'h0001) >= {1'b0, cur_len};

   always_comb begin
      state_d = state_q;
      cnt_d   = seg_end ? '0 : cnt_q + TW'(1);
      case (state_q)
         ST_IDLE: begin
            cnt_d = '0;
            if (vid_en_q) begin
               state_d = ST_SYNC;
            end
         end
         ST_SYNC: begin
            if (seg_end) begin
               state_d = ST_PORCH;
            end
         end
         ST_PORCH: begin
            if (seg_end) begin
               state_d = ST_ACT;
            end
         end
         ST_ACT: begin
            if (seg_end) begin
               state_d = ST_HFP;
            end
         end
         ST_HFP: begin
            if (seg_end) begin
               state_d = null_dly ? ST_NULD : ST_SYNC;
            end
         end
         ST_NULD: begin
            if (seg_end) begin
               state_d = ST_SYNC;
            end
         end
         default: begin
            state_d = ST_IDLE;
            cnt_d   = '0;
         end
      endcase
      if (!run) begin
         state_d = ST_IDLE;
         cnt_d   = '0;
      end
   end

   always_ff @(posedge LANE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         state_q <= ST_IDLE;
         cnt_q   <= '0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
      end
   end

   always_comb begin
      lane_v_d = 1'b0;
      lane_b_d = '0;
      case (state_q)
         ST_SYNC: begin
            lane_v_d = cnt_q < HSS_BYTES;
            lane_b_d = DT_HSS;
         end
         ST_PORCH: begin
            lane_v_d = send_bp;
            lane_b_d = send_bp ? DT_BLANK : 8'h00;
         end
         ST_ACT: begin
            lane_v_d = 1'b1;
            lane_b_d = PIX_DATA_I;
         end
         ST_NULD: begin
            lane_v_d = 1'b1;
            lane_b_d = DT_NULL;
         end
         default: begin
            lane_v_d = 1'b0;
            lane_b_d = '0;
         end
      endcase
   end

   always_ff @(posedge LANE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         LANE_VALID_O <= 1'b0;
         LANE_DATA_O  <= '0;
         PIX_READY_O  <= 1'b0;
      end else begin
         LANE_VALID_O <= lane_v_d;
         LANE_DATA_O  <= lane_b_d;
         PIX_READY_O  <= state_d == ST_ACT;
      end
   end

   // A toggle rather than a pulse, so no line start is lost in the crossing.
   always_ff @(posedge LANE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         line_tgl_q <= 1'b0;
      end else if (state_q != ST_SYNC && state_d == ST_SYNC) begin
         line_tgl_q <= ~line_tgl_q;
      end
   end

   assign line_sif.raw = line_tgl_q;

   // Command mode has no scheduler of its own here; its enable is kept only so
   // that cmd_idle_a can check video scheduling stays off while only command mode is chosen.
   logic cmd_only;
   assign cmd_only = cmd_en_q & ~vid_en_q;

   bp_idle_a: assert property (
      @(posedge LANE_CLK_I) disable iff (!RST_B_I)
      (state_q == ST_PORCH && !send_bp) |=> !LANE_VALID_O)
      else $error("lanes active in porch without blanking");

   bp_short_a: assert property (
      @(posedge LANE_CLK_I) disable iff (!RST_B_I)
      (state_q == ST_PORCH && l_porch_q < BLANK_MIN) |=> !LANE_VALID_O)
      else $error("blanking sent in short porch");

   // A hold that lands on the last front porch cycle sends the scheduler idle instead.
   null_gate_a: assert property (
      @(posedge LANE_CLK_I) disable iff (!RST_B_I)
      (run && state_q == ST_HFP && seg_end && !null_dly) |=> state_q == ST_SYNC)
      else $error("null delay applied without multiple packets");

   // The byte already launched from the cut line may still show for one cycle.
   core_hold_a: assert property (
      @(posedge LANE_CLK_I) disable iff (!RST_B_I)
      !run |=> state_q == ST_IDLE ##1 !LANE_VALID_O)
      else $error("link active while core held");

   cmd_idle_a: assert property (
      @(posedge LANE_CLK_I) disable iff (!RST_B_I)
      (cmd_only && state_q == ST_IDLE) |=> state_q == ST_IDLE)
      else $error("video scheduled in command mode");

   vid_write_a: assert property (
      @(posedge CLOCK_I) disable iff (!RST_B_I)
      (access && PWRITE_I && PADDR_I == OFF_VID)
      |=> vid_q[VID_EN_BIT] == $past(PWDATA_I[VID_EN_BIT]))
      else $error("video enable not stored");

   cmd_write_a: assert property (
      @(posedge CLOCK_I) disable iff (!RST_B_I)
      (access && PWRITE_I && PADDR_I == OFF_CMD)
      ##1 (PSEL_I == 1'b0 || PADDR_I != OFF_CMD)
      |-> cmd_q[CMD_EN_BIT] == $past(PWDATA_I[CMD_EN_BIT]))
      else $error("command enable not stored");

   pwr_hold_a: assert property (
      @(posedge CLOCK_I) disable iff (!RST_B_I)
      (access && PWRITE_I && PADDR_I == OFF_PWR && !PWDATA_I[PWR_BIT])
      |=> !pwr_q)
      else $error("core not held after zero write");

   ready_pulse_a: assert property (
      @(posedge CLOCK_I) disable iff (!RST_B_I)
      PREADY_O |=> !PREADY_O)
      else $error("ready held longer than one cycle");
endmodule

/* tb/dvt_panel_model.sv */
// Purpose: Panel side model that measures each video line seen on the lane.
// Assumes: Lane outputs settle between lane clock edges.
// Notes:   Pixel bytes keep bit 7 set so they never look like packet codes.
`timescale 1ns/1ps
module dvt_panel_model (
   input  wire logic        lane_clk_i,   // Lane byte clock.
   input  wire logic        clear_i,      // Restart measurement.
   input  wire logic [7:0]  lane_data_i,  // Lane byte.
   input  wire logic        lane_valid_i, // Lane byte valid.
   output logic      [7:0]  pix_data_o,   // Pixel byte source.
   output logic      [15:0] len_o,        // Last whole line length.
   output logic      [15:0] hss_o,        // Sync start bytes in it.
   output logic      [15:0] blank_o,      // Blanking bytes in it.
   output logic      [15:0] null_o,       // Null bytes in it.
   output logic      [15:0] pix_o,        // Pixel bytes in it.
   output logic      [15:0] valid_o       // Valid bytes since clear.
);
   logic [15:0] len_q, hss_q, blank_q, null_q, pix_q;
   logic        seen_q;
   logic        prev_q;
   logic        hss_now;

   assign hss_now = lane_valid_i && lane_data_i == 8'h21;

   // The source moves every cycle, so a stale byte cannot pass for a fresh one.
   initial pix_data_o = 8'h80;
   always @(posedge lane_clk_i) begin
      pix_data_o <= {1'b1, pix_data_o[6:0] + 7'h01};
      prev_q <= hss_now;
      if (clear_i) begin
         {seen_q, len_o, hss_o, blank_o, null_o, pix_o, valid_o} <= '0;
      end else begin
         valid_o <= valid_o + 16'(lane_valid_i);
         if (hss_now && prev_q !== 1'b1) begin
            if (seen_q) begin
               {len_o, hss_o, blank_o, null_o, pix_o} <= {len_q, hss_q, blank_q, null_q, pix_q};
            end
            seen_q <= 1'b1;
            {len_q, hss_q, blank_q, null_q, pix_q} <= {16'h0001, 16'h0001, 48'h0};
         end else begin
            len_q <= len_q + 16'h0001;
            hss_q <= hss_q + 16'(hss_now);
            blank_q <= blank_q + 16'(lane_valid_i && lane_data_i == 8'h19);
            null_q <= null_q + 16'(lane_valid_i && lane_data_i == 8'h09);
            pix_q <= pix_q + 16'(lane_valid_i && lane_data_i[7]);
         end
      end
   end
endmodule

/* tb/dvt_top_tb_top.sv */
// Purpose: Self-checking bench for the line timing block.
// Assumes: APB answers after one wait cycle; lane clock is free running.
// Notes:   Each mode row is programmed while the core is held.
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
   $display("mismatch %s exp %0h got %0h", n, e, g); end end
module dvt_top_tb_top;
   import dvt_pkg::*;
   logic          clk, rst_b, psel, pen, pwr, lclk, clr, rdy, err, lval, serr;
   logic [AW-1:0] paddr;
   logic [DW-1:0] pwd, prd, rd;
   logic [7:0]    pix, ldat;
   logic [15:0]   len, hss, blank, nul, npix, nval;
   int            num_errors, check_count;
   logic          pixrdy, hss_prev;
   int            starts, rdy_run, rdy_len;

   dvt_top dvt_top_inst (.CLOCK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(pen),
      .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(rdy),
      .PSLVERR_O(err), .LANE_CLK_I(lclk), .PIX_DATA_I(pix), .PIX_READY_O(pixrdy),
      .LANE_DATA_O(ldat), .LANE_VALID_O(lval));
   dvt_panel_model dvt_panel_model_inst (.lane_clk_i(lclk), .clear_i(clr), .lane_data_i(ldat),
      .lane_valid_i(lval), .pix_data_o(pix), .len_o(len), .hss_o(hss), .blank_o(blank),
      .null_o(nul), .pix_o(npix), .valid_o(nval));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      lclk = 1'b0;
      #7;
      forever #15 lclk = ~lclk;
   end

   // Line starts as the panel sees them, and the length of each pixel ready run.
   always @(posedge lclk) begin
      hss_prev <= lval && ldat == DT_HSS;
      if (lval && ldat == DT_HSS && !hss_prev) begin
         starts <= starts + 1;
      end
      if (clr) begin
         rdy_run <= 0;
         rdy_len <= 0;
      end else if (pixrdy) begin
         rdy_run <= rdy_run + 1;
      end else begin
         if (rdy_run != 0) begin
            rdy_len <= rdy_run;
         end
         rdy_run <= 0;
      end
   end

   // The request is held until pready is seen, then released after that edge.
   task automatic apb(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (rdy !== 1'b1 && n < 50);
      `CHK("apb_ready", 1'b1, rdy)
      rd = prd;
      serr = err;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask

   task automatic rd_chk(input string n, input logic [AW-1:0] a, input logic [DW-1:0] e);
      apb(1'b0, a, '0);
      `CHK(n, e, rd)
   endtask

   task automatic run_cfg(input logic [3:0] vc, input logic cmd, input logic [TW-1:0] bpl,
                          input logic [15:0] bl, input logic [15:0] nu);
      apb(1'b1, OFF_PWR, 32'h0);
      // Mode bits are only touched after the hold has reached the lane side.
      repeat (10) @(posedge clk);
      clr <= 1'b1;
      apb(1'b1, OFF_VID, {28'h0, vc});
      apb(1'b1, OFF_CMD, {31'h0, cmd});
      apb(1'b1, OFF_PORCH, {20'h0, bpl});
      apb(1'b1, OFF_ACT, 32'h8);
      repeat (4) @(posedge clk);
      clr <= 1'b0;
      repeat (20) @(posedge clk);
      `CHK("held_quiet", 16'h0, nval)
      rd_chk("line_count", OFF_STA, 32'(starts));
      apb(1'b1, OFF_PWR, 32'h1);
      repeat (400) @(posedge clk);
      if (!vc[0]) begin
         `CHK("video_off", 16'h0, nval)
      end else begin
         `CHK("line_len", 16'd27 + {4'h0, bpl} + nu, len)
         `CHK("hss_bytes", 16'h4, hss)
         `CHK("blank_bytes", bl, blank)
         `CHK("null_bytes", nu, nul)
         `CHK("pix_bytes", 16'h8, npix)
         `CHK("ready_len", 32'h8, rdy_len)
      end
   endtask

   task automatic end_of_test();
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial begin
      {rst_b, psel, pen, pwr, paddr, pwd, rd, serr, hss_prev} = '0;
      {starts, rdy_run, rdy_len} = '0;
      clr = 1'b1;
      num_errors = 0;
      check_count = 0;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      rd_chk("pwr_reset", OFF_PWR, 32'h0);
      rd_chk("porch_reset", OFF_PORCH, {20'h0, PORCH_RST});
      apb(1'b1, OFF_CMD, 32'h1);
      rd_chk("cmd_en", OFF_CMD, 32'h1);
      apb(1'b0, 8'h48, '0);
      `CHK("unmapped_err", 1'b1, serr)
      `CHK("unmapped_data", 32'h0, rd)
      // Sync width stays at 11, above 10 lane cycles.
      run_cfg(4'hF, 1'b0, 12'd11, 16'd11, 16'd4);
      run_cfg(4'hB, 1'b0, 12'd5, 16'd0, 16'd0);
      run_cfg(4'h5, 1'b0, 12'd6, 16'd0, 16'd0);
      run_cfg(4'hD, 1'b0, 12'd6, 16'd6, 16'd0);
      run_cfg(4'h0, 1'b1, 12'd11, 16'd0, 16'd0);
      end_of_test();
   end

   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      end_of_test();
   end
endmodule
